// [src/psram_config_refresh_ctrl.sv]
// configuration registers, power states and refresh scheduler of the memory device
`default_nettype none
// Operation
// R1 - fixed latency drives strobe high during command
// R2 - fixed latency enabled after any reset
// R3 - variable latency: strobe high only for refresh
// R4 - three-bit drive strength, reset 000b
// R5 - writing zero enters deep power down
// R6 - select low-high or reset exits power down
// R7 - power down ignores all but select, reset; register reads are still answered here
// R8 - host writes ones to upper reserved byte
// R9 - host writes one to reserved bit seven
// R10 - bit six selects single or differential clock
// R11 - writing one enters hybrid sleep
// R12 - select low ends sleep, clears bit
// R13 - reset ending sleep voids array contents
// R14 - three-bit partial array refresh region
// R15 - refresh interval field reads 01b
// R16 - self refresh evenly spaced, no command
// R17 - refresh waits until transaction ends
// R18 - pending refresh adds latency, strobe high
// R19 - host keeps select low under 4us
// R20 - latency field three to seven, default seven
// R21 - interval field ignores writes
module psram_config_refresh_ctrl #(
   parameter int REFRESH_OP_CYCLES = psram_cfg_pkg::REFRESH_OP_DEFAULT
) (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [1:0] regAddr,
   input wire logic [15:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [15:0] regRdData,
   input wire logic csN,
   input wire logic hwRstN,
   input wire logic linkClk,
   output logic rwdsOut,
   output logic rwdsOe,
   output logic [2:0] driveStrength,
   output logic [3:0] latencyClocks,
   output logic clockSingleEnded,
   output logic hybridSleep,
   output logic deepPowerDown,
   output logic refreshActive,
   output logic [2:0] refreshRegion
);
   import psram_cfg_pkg::*;

   localparam int TW = $clog2(REFRESH_TICKS);
   localparam logic [TW-1:0] REF_LAST = TW'(REFRESH_TICKS - 1);
   localparam logic [7:0] OP_LAST = 8'(REFRESH_OP_CYCLES - 1);

   if (REFRESH_OP_CYCLES < 1 || REFRESH_OP_CYCLES > 255 ||
       REFRESH_OP_CYCLES >= REFRESH_TICKS) begin : g_bad
      $error("refresh operation length out of range");
   end

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   logic [2:0] pinMeta_reg;
   logic [2:0] pinSync_reg;
   logic csPrev_reg;
   logic ckPrev_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pinMeta_reg <= PIN_IDLE;
         pinSync_reg <= PIN_IDLE;
         csPrev_reg <= 1'b1;
         ckPrev_reg <= 1'b0;
      end else begin
         pinMeta_reg <= {linkClk, hwRstN, csN};
         pinSync_reg <= pinMeta_reg;
         csPrev_reg <= pinSync_reg[PIN_CS];
         ckPrev_reg <= pinSync_reg[PIN_CK];
      end
   end

   wire csLow = !pinSync_reg[PIN_CS];
   wire csFall = csPrev_reg && csLow;
   wire csRise = !csPrev_reg && !csLow;
   wire linkEdge = ckPrev_reg ^ pinSync_reg[PIN_CK];
   wire hwReset = !pinSync_reg[PIN_HWRST];

   // ----------------------------------------
   // configuration registers
   // ----------------------------------------
   logic fixedLat_reg;
   logic [2:0] drvStr_reg;
   logic [3:0] latency_reg;
   logic dpd_reg;
   logic clkSingle_reg;
   logic hs_reg;
   logic [2:0] par_reg;
   logic [8:0] cr1Rsvd_reg;
   logic lost_reg;
   logic [15:0] regRdData_reg;
   refresh_state_t refState_reg;

   // leaving power down restores the power-on state of every register
   wire dpdExit = dpd_reg && csRise; // [R6]
   wire softClear = hwReset || dpdExit; // [R6]
   // in power down only select, hardware reset and register reads are watched
   wire wrEn = regWr && !dpd_reg && !hwReset; // [R7]
   wire wrCr0 = wrEn && (regAddr == ADDR_CR0);
   wire wrCr1 = wrEn && (regAddr == ADDR_CR1);
   wire wrSt = wrEn && (regAddr == ADDR_STATUS);
   wire [3:0] latWr = regWrData[CR0_LAT_LSB +: 4];
   wire latOk = (latWr >= LAT_MIN) && (latWr <= LAT_MAX); // [R20]
   wire dpdEnter = wrCr0 && !regWrData[CR0_DPD_BIT]; // [R5]

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         fixedLat_reg <= 1'b1;
         drvStr_reg <= DRV_RESET;
         latency_reg <= LAT_RESET;
         dpd_reg <= 1'b0;
      end else if (softClear) begin
         fixedLat_reg <= 1'b1; // [R2]
         drvStr_reg <= DRV_RESET; // [R4]
         latency_reg <= LAT_RESET; // [R20]
         dpd_reg <= 1'b0; // [R6]
      end else if (wrCr0) begin
         fixedLat_reg <= regWrData[CR0_FIXED_BIT]; // [R1] [R3]
         drvStr_reg <= regWrData[CR0_DRV_LSB +: 3]; // [R4]
         latency_reg <= latOk ? latWr : latency_reg; // [R20]
         dpd_reg <= dpdEnter; // [R5]
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         clkSingle_reg <= 1'b1;
         par_reg <= PAR_RESET;
         cr1Rsvd_reg <= CR1_RSVD_RESET;
      end else if (softClear) begin
         clkSingle_reg <= 1'b1; // [R10]
         par_reg <= PAR_RESET; // [R14]
         cr1Rsvd_reg <= CR1_RSVD_RESET;
      end else if (wrCr1) begin
         clkSingle_reg <= regWrData[CR1_CLK_BIT]; // [R10]
         par_reg <= regWrData[CR1_PAR_LSB +: 3]; // [R14]
         cr1Rsvd_reg <= regWrData[CR1_RSVD_LSB +: 9]; // [R8] [R9]
      end
   end

   // select going low ends sleep even if a write lands the same cycle
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         hs_reg <= 1'b0;
      end else if (softClear || csFall) begin
         hs_reg <= 1'b0; // [R12]
      end else if (wrCr1) begin
         hs_reg <= regWrData[CR1_HS_BIT]; // [R11]
      end
   end

   // contents-lost flag: set by power down or hardware reset, set beats clear
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         lost_reg <= 1'b1;
      end else if (hwReset || dpdEnter) begin
         lost_reg <= 1'b1; // [R13] [R5]
      end else if (wrSt && regWrData[ST_LOST_BIT]) begin
         lost_reg <= 1'b0;
      end
   end

   // ----------------------------------------
   // register read port
   // ----------------------------------------
   // interval code is a constant, so writes cannot disturb it
   wire [15:0] cr0View = {!dpd_reg, drvStr_reg, 4'h0, latency_reg, fixedLat_reg, 3'h0};
   wire [15:0] cr1View = {cr1Rsvd_reg, clkSingle_reg, hs_reg, par_reg,
                          INTERVAL_CODE}; // [R15] [R21]
   wire [15:0] stView = {13'h0, refState_reg, lost_reg};
   wire [15:0] rdMux = (regAddr == ADDR_CR0) ? cr0View :
                       (regAddr == ADDR_CR1) ? cr1View :
                       (regAddr == ADDR_STATUS) ? stView : 16'h0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData_reg <= 16'h0;
      end else begin
         regRdData_reg <= regRd ? rdMux : 16'h0;
      end
   end

   // ----------------------------------------
   // refresh scheduler
   // ----------------------------------------
   logic [TW-1:0] refTimer_reg;
   logic [7:0] opCnt_reg;
   refresh_state_t refState_next;
   // refresh halts in power down and while hardware reset is held
   wire refRun = !dpd_reg && !hwReset; // [R5] [R13]
   wire refTick = refRun && (refTimer_reg == REF_LAST); // [R16]

   always_comb begin
      refState_next = refState_reg;
      case (refState_reg)
         REF_IDLE: begin
            if (refTick) begin
               refState_next = REF_PENDING; // [R16]
            end
         end
         REF_PENDING: begin
            if (!csLow) begin
               refState_next = REF_BUSY; // [R17]
            end
         end
         REF_BUSY: begin
            if (opCnt_reg == OP_LAST) begin
               refState_next = REF_IDLE;
            end
         end
         default: begin
            refState_next = REF_IDLE;
         end
      endcase
      if (!refRun) begin
         refState_next = REF_IDLE;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         refState_reg <= REF_IDLE;
         refTimer_reg <= '0;
         opCnt_reg <= 8'h0;
      end else begin
         refState_reg <= refState_next;
         refTimer_reg <= (!refRun || refTick) ? '0 : refTimer_reg + 1'b1; // [R16]
         opCnt_reg <= (refState_reg == REF_BUSY) ? opCnt_reg + 8'h1 : 8'h0;
      end
   end

   // ----------------------------------------
   // strobe during the command phase
   // ----------------------------------------
   logic [2:0] caCnt_reg;
   logic extraLat_reg;
   logic rwdsOut_reg;
   logic rwdsOe_reg;
   logic refActive_reg;
   // the device cannot tell register writes apart here; high is legal for them
   wire inCa = csLow && (caCnt_reg < CA_EDGES) && !dpd_reg;
   wire extraNext = csFall ? (refState_reg != REF_IDLE) : // [R18]
                    (csLow && extraLat_reg);
   wire [2:0] caNext = !csLow ? 3'h0 :
                       (linkEdge && caCnt_reg < CA_EDGES) ? caCnt_reg + 3'h1 : caCnt_reg;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         caCnt_reg <= 3'h0;
         extraLat_reg <= 1'b0;
         rwdsOut_reg <= 1'b0;
         rwdsOe_reg <= 1'b0;
         refActive_reg <= 1'b0;
      end else begin
         caCnt_reg <= caNext;
         extraLat_reg <= extraNext;
         rwdsOut_reg <= inCa && (fixedLat_reg || extraNext); // [R1] [R3] [R18]
         rwdsOe_reg <= inCa;
         refActive_reg <= (refState_next == REF_BUSY);
      end
   end

   assign regRdData = regRdData_reg;
   assign rwdsOut = rwdsOut_reg;
   assign rwdsOe = rwdsOe_reg;
   assign driveStrength = drvStr_reg;
   assign latencyClocks = latency_reg;
   assign clockSingleEnded = clkSingle_reg;
   assign hybridSleep = hs_reg;
   assign deepPowerDown = dpd_reg;
   assign refreshActive = refActive_reg;
   assign refreshRegion = par_reg;

   // ----------------------------------------
   // checks
   // ----------------------------------------
   property p_fixed_high;
      @(posedge sys_clk) disable iff (rst)
      rwdsOe_reg && $past(fixedLat_reg) |-> rwdsOut_reg;
   endproperty
   a_fixed_high: assert property (p_fixed_high) else $error("strobe low under fixed latency"); // [R1]

   property p_reset_values;
      @(posedge sys_clk) disable iff (rst)
      $past(hwReset) && !hwReset |-> fixedLat_reg && drvStr_reg == DRV_RESET
         && latency_reg == LAT_RESET && !hs_reg;
   endproperty
   a_reset_values: assert property (p_reset_values) else $error("bad value after reset"); // [R2]

   property p_variable_low;
      @(posedge sys_clk) disable iff (rst)
      rwdsOe_reg && !$past(fixedLat_reg) && !extraLat_reg |-> !rwdsOut_reg;
   endproperty
   a_variable_low: assert property (p_variable_low) else $error("strobe high without refresh"); // [R3]

   property p_dpd_enter;
      @(posedge sys_clk) disable iff (rst)
      dpdEnter && !hwReset |=> dpd_reg ##1 (refState_reg == REF_IDLE);
   endproperty
   a_dpd_enter: assert property (p_dpd_enter) else $error("power down not entered"); // [R5]

   property p_dpd_hold;
      @(posedge sys_clk) disable iff (rst)
      dpd_reg && !csRise && !hwReset |=> dpd_reg && $stable(drvStr_reg) && !refActive_reg;
   endproperty
   a_dpd_hold: assert property (p_dpd_hold) else $error("power down disturbed"); // [R7]

   property p_sleep_wake;
      @(posedge sys_clk) disable iff (rst)
      csFall |=> !hs_reg;
   endproperty
   a_sleep_wake: assert property (p_sleep_wake) else $error("sleep not ended by select"); // [R12]

   property p_interval_code;
      @(posedge sys_clk) disable iff (rst)
      regRd && regAddr == ADDR_CR1 |=> regRdData[1:0] == INTERVAL_CODE;
   endproperty
   a_interval_code: assert property (p_interval_code) else $error("interval code changed"); // [R15]

   property p_defer;
      @(posedge sys_clk) disable iff (rst)
      refState_reg == REF_PENDING && csLow |=> refState_reg != REF_BUSY;
   endproperty
   a_defer: assert property (p_defer) else $error("refresh inside transaction"); // [R17]

   property p_extra;
      @(posedge sys_clk) disable iff (rst)
      csFall && refState_reg != REF_IDLE && !dpd_reg |=> extraLat_reg && rwdsOut_reg;
   endproperty
   a_extra: assert property (p_extra) else $error("no extra latency signalled"); // [R18]
endmodule
`default_nettype wire

// [include/psram_cfg_pkg.sv]
// constants shared by the configuration and refresh controller
`default_nettype none
package psram_cfg_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 50;
   localparam int REFRESH_INTERVAL_NS = 4000;
   localparam int REFRESH_TICKS = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
   localparam int REFRESH_OP_DEFAULT = 4;
   localparam logic [2:0] CA_EDGES = 3'h6;
   // register indices on the local port
   localparam logic [1:0] ADDR_CR0 = 2'h0;
   localparam logic [1:0] ADDR_CR1 = 2'h1;
   localparam logic [1:0] ADDR_STATUS = 2'h2;
   // config_reg_zero layout
   localparam int CR0_DPD_BIT = 15;
   localparam int CR0_DRV_LSB = 12;
   localparam int CR0_LAT_LSB = 4;
   localparam int CR0_FIXED_BIT = 3;
   localparam logic [2:0] DRV_RESET = 3'h0;
   localparam logic [3:0] LAT_RESET = 4'h7;
   localparam logic [3:0] LAT_MIN = 4'h3;
   localparam logic [3:0] LAT_MAX = 4'h7;
   // config_reg_one layout
   localparam int CR1_RSVD_LSB = 7;
   localparam int CR1_CLK_BIT = 6;
   localparam int CR1_HS_BIT = 5;
   localparam int CR1_PAR_LSB = 2;
   localparam logic [8:0] CR1_RSVD_RESET = 9'h1FF;
   localparam logic [2:0] PAR_RESET = 3'h0;
   localparam logic [1:0] INTERVAL_CODE = 2'h1;
   // status layout
   localparam int ST_LOST_BIT = 0;
   // synchronised pins
   localparam int PIN_CS = 0;
   localparam int PIN_HWRST = 1;
   localparam int PIN_CK = 2;
   localparam logic [2:0] PIN_IDLE = 3'h3;
   typedef enum logic [1:0] {REF_IDLE, REF_PENDING, REF_BUSY} refresh_state_t;
endpackage
`default_nettype wire

// [verification/host_link_model.sv]
// host controller model: drives select, bus clock and hardware reset
`default_nettype none
module host_link_model (
   input wire logic sys_clk,
   input wire logic rwdsOut,
   input wire logic rwdsOe,
   output logic csN,
   output logic linkClk,
   output logic hwRstN
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      csN = 1'b1;
      linkClk = 1'b0;
      hwRstN = 1'b1;
   end
   // ----------------------------------------
   // one select frame with a three-clock command phase
   // ----------------------------------------
   // the bus clock is timed by delays, so its phase floats against sys_clk
   task automatic frame(input int extra, output logic oeSeen, output logic strobe);
      oeSeen = 1'b0;
      strobe = 1'b0;
      @(posedge sys_clk);
      csN <= 1'b0;
      repeat (8) begin
         @(negedge sys_clk);
         if (rwdsOe === 1'b1) begin
            oeSeen = 1'b1;
            strobe = rwdsOut;
         end
      end
      #37;
      repeat (6) begin
         linkClk = ~linkClk;
         #200;
      end
      repeat (extra) @(posedge sys_clk);
      @(posedge sys_clk);
      csN <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic hw_reset;
      @(posedge sys_clk);
      hwRstN <= 1'b0;
      repeat (6) @(posedge sys_clk);
      hwRstN <= 1'b1;
      repeat (4) @(posedge sys_clk);
   endtask
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench of the configuration and refresh controller
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import psram_cfg_pkg::*;
   logic sys_clk = 0, rst = 1, regWr = 0, regRd = 0, refPrev = 0;
   logic [1:0] regAddr = 2'h0;
   logic [15:0] regWrData = 16'h0000, regRdData, rd;
   logic csN, hwRstN, linkClk, rwdsOut, rwdsOe, clockSingleEnded, hybridSleep;
   logic deepPowerDown, refreshActive, oe, st;
   logic [2:0] driveStrength, refreshRegion;
   logic [3:0] latencyClocks;
   int n_mismatch = 0, compares = 0, cyc = 0, lowCnt = 0, a;
   initial begin
      forever #25 sys_clk = ~sys_clk;
   end
   psram_config_refresh_ctrl psram_config_refresh_ctrl_i (.sys_clk(sys_clk), .rst(rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .csN(csN), .hwRstN(hwRstN), .linkClk(linkClk),
      .rwdsOut(rwdsOut), .rwdsOe(rwdsOe), .driveStrength(driveStrength),
      .latencyClocks(latencyClocks), .clockSingleEnded(clockSingleEnded),
      .hybridSleep(hybridSleep), .deepPowerDown(deepPowerDown),
      .refreshActive(refreshActive), .refreshRegion(refreshRegion));
   host_link_model host_link_model_i (.sys_clk(sys_clk), .rwdsOut(rwdsOut), .rwdsOe(rwdsOe),
      .csN(csN), .linkClk(linkClk), .hwRstN(hwRstN));
   // ----------------------------------------
   // checking and register port
   // ----------------------------------------
   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task print_verdict;
      $display("compares=%0d mismatches=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   function logic [15:0] outs();
      return {3'h0, driveStrength, latencyClocks, refreshRegion, clockSingleEnded,
         hybridSleep, deepPowerDown};
   endfunction
   task wr(input logic [1:0] ad, input logic [15:0] d);
      @(posedge sys_clk);
      regWr <= 1'b1;
      regAddr <= ad;
      regWrData <= d;
      @(posedge sys_clk);
      regWr <= 1'b0;
      @(negedge sys_clk);
   endtask
   task rdr(input logic [1:0] ad);
      @(posedge sys_clk);
      regRd <= 1'b1;
      regAddr <= ad;
      @(posedge sys_clk);
      regRd <= 1'b0;
      @(negedge sys_clk);
      rd = regRdData;
   endtask
   // a refresh must never start while select has been low for a while
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      lowCnt <= csN ? 0 : lowCnt + 1;
      refPrev <= refreshActive;
      if (refreshActive && !refPrev && lowCnt > 3) chk(16'h0001, 16'h0000);
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      rdr(ADDR_CR0); chk(rd, 16'h8078);
      rdr(ADDR_CR1); chk(rd, 16'hFFC1);
      rdr(2'h3); chk(rd, 16'h0000);
      chk(outs(), 16'h01C4);
   endtask
   task t_fields;
      logic [15:0] v;
      wr(ADDR_CR0, 16'hF078); chk(outs(), 16'h1DC4);
      wr(ADDR_CR0, 16'h8028); chk(outs(), 16'h01C4);
      wr(ADDR_CR0, 16'h8038); chk(outs(), 16'h00C4);
      wr(ADDR_CR0, 16'h8078);
      for (int c = 0; c < 8; c++) begin
         v = 16'hFF80 | (16'(c) << 2);
         wr(ADDR_CR1, v);
         rdr(ADDR_CR1);
         if (c != 4) chk(16'(refreshRegion), 16'(c));
         if (c != 4) chk(rd, v | 16'h0001);
      end
      chk(16'(clockSingleEnded), 16'h0000);
      wr(ADDR_CR1, 16'hFFC1);
   endtask
   task t_latency;
      host_link_model_i.frame(0, oe, st); chk(16'({oe, st}), 16'h0003);
      wr(ADDR_CR0, 16'h8070);
      @(negedge refreshActive);
      host_link_model_i.frame(0, oe, st); chk(16'({oe, st}), 16'h0002);
      @(posedge refreshActive);
      host_link_model_i.frame(0, oe, st); chk(16'({oe, st}), 16'h0003);
      wr(ADDR_CR0, 16'h8078);
   endtask
   task t_refresh;
      // read the cycle count off the edge, once the counter has settled
      @(posedge refreshActive);
      @(negedge sys_clk);
      a = cyc;
      @(posedge refreshActive);
      @(negedge sys_clk);
      chk(16'(cyc - a), 16'(REFRESH_TICKS));
      // a long frame so that the next refresh falls due inside it
      @(negedge refreshActive);
      host_link_model_i.frame(42, oe, st);
      a = 0;
      repeat (20) @(negedge sys_clk) if (refreshActive === 1'b1) a = 1;
      chk(16'(a), 16'h0001);
   endtask
   task t_dpd;
      wr(ADDR_CR0, 16'h0078); chk(outs(), 16'h01C5);
      a = 0;
      repeat (200) @(negedge sys_clk) if (refreshActive !== 1'b0) a = 1;
      chk(16'(a), 16'h0000);
      wr(ADDR_CR1, 16'hFFE1); chk(outs(), 16'h01C5);
      host_link_model_i.frame(0, oe, st); chk(16'(oe), 16'h0000);
      // the frame returns on the edge that wakes the device; look once it has settled
      @(negedge sys_clk);
      chk(outs(), 16'h01C4);
      rdr(ADDR_CR0); chk(rd, 16'h8078);
   endtask
   task t_sleep;
      wr(ADDR_CR1, 16'hFFE1); chk(outs(), 16'h01C6);
      host_link_model_i.frame(0, oe, st);
      rdr(ADDR_CR1); chk(rd, 16'hFFC1);
      wr(ADDR_CR0, 16'hF038);
      wr(ADDR_CR1, 16'hFFE1);
      wr(ADDR_STATUS, 16'h0001);
      rdr(ADDR_STATUS); chk(rd & 16'h0001, 16'h0000);
      host_link_model_i.hw_reset();
      rdr(ADDR_STATUS); chk(rd & 16'h0001, 16'h0001);
      chk(outs(), 16'h01C4);
      rdr(ADDR_CR0); chk(rd, 16'h8078);
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (3) @(posedge sys_clk);
      t_reset();
      t_fields();
      t_latency();
      t_refresh();
      t_dpd();
      t_sleep();
      print_verdict();
   end
endmodule
`default_nettype wire
